// File: common/cm_pkg.sv
package cm_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_CFG0 = 8'h00;
	localparam logic [7:0] ADDR_PIN_CFG1 = 8'h10;
	localparam logic [7:0] ADDR_DIG_MASK = 8'h35;
	localparam logic [7:0] ADDR_LIMITS = 8'h78;
	localparam logic [7:0] ADDR_VALUE = 8'h97;
	localparam logic [7:0] ADDR_DIG_STATUS = 8'hBE;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int TABLE_SEL_BIT = 6;
	localparam int MON_EN_BIT = 7;
	localparam int MISMATCH_BIT = 6;
	localparam int LINE6 = 6;
	localparam logic [7:0] CFG0_RST = 8'h00;
	localparam logic [7:0] PIN_CFG1_RST = 8'h00;
	localparam logic [7:0] DIG_MASK_RST = 8'h00;
	localparam logic [7:0] LIMITS_RST = 8'h00;

	// ----------------------------------------
	// timing, clock is 10 MHz
	// ----------------------------------------
	localparam int CLK_MHZ = 10;
	localparam int SAMPLE_US = 11;
	localparam int STABLE_US = 55;
	localparam int SAMPLE_CYCLES = SAMPLE_US * CLK_MHZ;
	localparam logic [6:0] SAMPLE_LAST = 7'(SAMPLE_CYCLES - 1);
	localparam logic [2:0] STABLE_SAMPLES = 3'(STABLE_US / SAMPLE_US);

	// ----------------------------------------
	// voltages in units of 1.25 mV
	// ----------------------------------------
	localparam int VOLT_W = 12;
	// 6.25 mV on line 0, doubling per line up to 400 mV on line 6 [R6]
	localparam logic [6:0][9:0] EXT_WEIGHT = {10'h140, 10'h0A0, 10'h050, 10'h028,
		10'h014, 10'h00A, 10'h005};
	// 400/200/100/60/25 mV on lines 4..0, 12.5 mV on line 5, line 6 unused [R7]
	localparam logic [6:0][9:0] LEG_WEIGHT = {10'h000, 10'h00A, 10'h140, 10'h0A0,
		10'h050, 10'h030, 10'h014};
	// valid decoded range 0.8375 V to 1.6 V [R17]
	localparam logic [11:0] CODE_MIN_U = 12'h29E;
	localparam logic [11:0] CODE_MAX_U = 12'h500;
	// rail lsb: 12.5 mV while monitoring, 6.25 mV otherwise [R8]
	localparam logic [11:0] RAIL_UNIT_MON = 12'h00A;
	localparam logic [11:0] RAIL_UNIT_NORM = 12'h005;
	// limit steps: high 25 mV, low 12.5 mV [R12]
	localparam logic [11:0] HIGH_STEP = 12'h014;
	localparam logic [11:0] LOW_STEP = 12'h00A;

	// ----------------------------------------
	// carriers and state
	// ----------------------------------------
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cm_reg_req_t;

	typedef struct packed {
		logic [11:0] volt;
	} cm_dec_state_t;

	typedef struct packed {
		logic [7:0] cfg0;
		logic [7:0] pin_cfg1;
		logic [7:0] mask;
		logic [7:0] limits;
		logic [6:0] value;
		logic [6:0] sample_cnt;
		logic [2:0] stable_cnt;
		logic [7:0] rail;
		logic fault;
		logic status;
		logic [7:0] rdata;
		logic alert_oe;
		logic pin_mode;
	} cm_state_t;

endpackage

// File: hw/cm_code_decode.sv
`timescale 1ns/1ps

module cm_code_decode (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [6:0] code_in,
	input wire logic ext_sel_in,
	output logic [11:0] volt_out
);

	cm_pkg::cm_dec_state_t st;
	cm_pkg::cm_dec_state_t next_st;
	logic [11:0] sum;

	// weighted sum below the top of range, then clamped to the valid span [R21]
	always_comb begin
		sum = 12'h000;
		for (int i = 0; i < 7; i++) begin
			if (code_in[i]) begin
				if (ext_sel_in) begin
					sum = sum + {2'b00, cm_pkg::EXT_WEIGHT[i]};
				end else begin
					sum = sum + {2'b00, cm_pkg::LEG_WEIGHT[i]};
				end
			end
		end
		next_st.volt = cm_pkg::CODE_MAX_U - sum;
		if (next_st.volt < cm_pkg::CODE_MIN_U) begin
			next_st.volt = cm_pkg::CODE_MIN_U; // [R17]
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign volt_out = st.volt;

	// the decode register holds zero through reset, so look only once it has reloaded
	AST_DECODE_RANGE: assert property (@(posedge clk_in) disable iff (rst_in) // [R17]
		!$past(rst_in) |-> (volt_out >= cm_pkg::CODE_MIN_U && volt_out <= cm_pkg::CODE_MAX_U))
		else $error("decoded voltage outside valid range");

endmodule

// File: hw/cm_monitor.sv
`timescale 1ns/1ps

// What this block does
// R1: monitoring runs only while pin config 1 bit 7 is one.
// R2: enabling switches all seven shared pins to code inputs together.
// R3: value register holds sampled code, bit n copying code line n.
// R4: legacy table by default, extended table when config 0 bit 6 set.
// R5: in legacy mode code line 6 is reported as zero.
// R6: extended weights run binary from 400 mV down to 6.25 mV.
// R7: legacy weights 400/200/100/60/25 mV lines 4..0, 12.5 mV line 5.
// R8: only core rail 1 is compared; its lsb becomes 12.5 mV.
// R9: code lines sampled every 11 us, value register updated each sample.
// R10: comparison starts only after code unchanged for 55 us.
// R11: stable code decoded with the currently selected table.
// R12: limit register: high nibble 25 mV steps, low nibble 12.5 mV steps.
// R13: mismatch if rail above value plus high, or at/below value minus low.
// R14: host keeps the low limit at one or more to avoid constant alert.
// R15: mismatch sets digital status bit 6, which drives alert unless masked.
// R16: status read clears the bit and alert only when back in window.
// R17: valid codes mean core voltages from 0.8375 V to 1.6 V.
// R18: a set status bit stays set until read and the fault ended.
// R19: a mask bit blocks alert but the status bit still sets.
// R20: alert stays asserted while the fault lasts and until read.
// R21: full code to voltage decode covers both tables.
// R22: any code change restarts stability; no evaluation while changing.
module cm_monitor (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [6:0] code_lines_in,
	input wire logic [7:0] rail_code_in,
	input wire logic rail_valid_in,
	input cm_pkg::cm_reg_req_t reg_req_in,
	output logic [7:0] reg_rdata_out,
	output logic code_input_mode_out,
	output logic alert_n_out,
	output logic alert_oe_out
);

	// ----------------------------------------
	// state and decode
	// ----------------------------------------
	cm_pkg::cm_state_t st;
	cm_pkg::cm_state_t next_st;

	logic enable;
	logic ext_sel;
	logic tick;
	logic stable_now;
	logic code_change;
	logic read_status;
	logic mismatch;
	logic [6:0] sampled;
	logic [11:0] decoded;
	logic [11:0] rail_unit;
	logic [11:0] rail_u;
	logic [11:0] win_high;
	logic [11:0] win_low;

	assign enable = st.pin_cfg1[cm_pkg::MON_EN_BIT]; // [R1]
	assign ext_sel = st.cfg0[cm_pkg::TABLE_SEL_BIT]; // [R4]
	assign tick = (st.sample_cnt == cm_pkg::SAMPLE_LAST);
	assign stable_now = (st.stable_cnt == cm_pkg::STABLE_SAMPLES);
	assign read_status = reg_req_in.rd && (reg_req_in.addr == cm_pkg::ADDR_DIG_STATUS);

	// decode always follows the live table select, so a table change is
	// seen within one cycle of the next comparison
	cm_code_decode u_decode ( // [R6] [R7] [R17] [R21]
		.clk_in(clk_in),
		.rst_in(rst_in),
		.code_in(st.value),
		.ext_sel_in(ext_sel), // [R11]
		.volt_out(decoded)
	);

	// ----------------------------------------
	// code sampling
	// ----------------------------------------
	always_comb begin
		sampled = code_lines_in;
		if (!ext_sel) begin
			sampled[cm_pkg::LINE6] = 1'b0; // [R5]
		end
	end

	assign code_change = enable && tick && (sampled != st.value);

	// ----------------------------------------
	// window compare
	// ----------------------------------------
	// rail scale doubles while monitoring so the code fits one byte of rail
	assign rail_unit = enable ? cm_pkg::RAIL_UNIT_MON : cm_pkg::RAIL_UNIT_NORM; // [R8]
	assign rail_u = 12'({4'h0, st.rail} * rail_unit);
	assign win_high = decoded + 12'({8'h00, st.limits[7:4]} * cm_pkg::HIGH_STEP); // [R12]
	assign win_low = decoded - 12'({8'h00, st.limits[3:0]} * cm_pkg::LOW_STEP); // [R12]
	// decoded never falls below 670 units, so win_low cannot wrap
	assign mismatch = (rail_u > win_high) || (rail_u <= win_low); // [R13]

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;

		// register writes
		if (reg_req_in.wr) begin
			case (reg_req_in.addr)
				cm_pkg::ADDR_CFG0: begin
					next_st.cfg0 = reg_req_in.wdata;
				end
				cm_pkg::ADDR_PIN_CFG1: begin
					next_st.pin_cfg1 = reg_req_in.wdata;
				end
				cm_pkg::ADDR_DIG_MASK: begin
					next_st.mask = reg_req_in.wdata;
				end
				cm_pkg::ADDR_LIMITS: begin
					next_st.limits = reg_req_in.wdata;
				end
				default: begin
					next_st.cfg0 = st.cfg0;
				end
			endcase
		end

		// register reads, answered one cycle after the strobe
		if (reg_req_in.rd) begin
			case (reg_req_in.addr)
				cm_pkg::ADDR_CFG0: begin
					next_st.rdata = st.cfg0;
				end
				cm_pkg::ADDR_PIN_CFG1: begin
					next_st.rdata = st.pin_cfg1;
				end
				cm_pkg::ADDR_DIG_MASK: begin
					next_st.rdata = st.mask;
				end
				cm_pkg::ADDR_LIMITS: begin
					next_st.rdata = st.limits;
				end
				cm_pkg::ADDR_VALUE: begin
					next_st.rdata = {1'b0, st.value}; // [R3]
				end
				cm_pkg::ADDR_DIG_STATUS: begin
					next_st.rdata = {1'b0, st.status, 6'h00};
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end

		// free running 11 us sample divider
		if (tick) begin
			next_st.sample_cnt = 7'h00;
		end else begin
			next_st.sample_cnt = st.sample_cnt + 7'h01;
		end

		if (!enable) begin
			next_st.value = 7'h00;
			next_st.stable_cnt = 3'h0;
			next_st.fault = 1'b0;
		end else begin
			if (tick) begin
				next_st.value = sampled; // [R3] [R9]
				if (code_change) begin
					next_st.stable_cnt = 3'h0; // [R22]
				end else if (!stable_now) begin
					next_st.stable_cnt = st.stable_cnt + 3'h1; // [R10]
				end
			end
			// fault level only moves once the code has settled
			if (stable_now && !code_change) begin
				next_st.fault = mismatch; // [R10] [R13] [R22]
			end
		end

		// rail 1 sample from the converter
		if (rail_valid_in) begin
			next_st.rail = rail_code_in; // [R8]
		end

		// sticky status: a live fault wins over a clearing read
		next_st.status = st.fault || (st.status && !read_status); // [R15] [R16] [R18]

		// the host is trusted to keep the low limit nonzero [R14]
		next_st.alert_oe = next_st.status && !next_st.mask[cm_pkg::MISMATCH_BIT]; // [R19] [R20]
		next_st.pin_mode = next_st.pin_cfg1[cm_pkg::MON_EN_BIT]; // [R2]
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= '0;
			st.cfg0 <= cm_pkg::CFG0_RST;
			st.pin_cfg1 <= cm_pkg::PIN_CFG1_RST;
			st.mask <= cm_pkg::DIG_MASK_RST;
			st.limits <= cm_pkg::LIMITS_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// alert is open drain: the level is always low, only the enable moves
	assign reg_rdata_out = st.rdata;
	assign code_input_mode_out = st.pin_mode;
	assign alert_oe_out = st.alert_oe;
	assign alert_n_out = 1'b0;

	// ----------------------------------------
	// checking helpers
	// ----------------------------------------
	logic [9:0] chg_age;
	logic chg_seen;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			chg_age <= 10'h000;
			chg_seen <= 1'b0;
		end else begin
			if (code_change) begin
				chg_age <= 10'h000;
				chg_seen <= 1'b1;
			end else if (chg_age != 10'h3FF) begin
				chg_age <= chg_age + 10'h001;
			end
			if (!enable) begin
				chg_seen <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_status_read_clean;
		read_status && !st.fault;
	endsequence

	sequence s_in_window;
		enable && stable_now && !code_change && !mismatch;
	endsequence

	AST_OFF_NO_FAULT: assert property ( // [R1]
		!enable |=> !st.fault && st.value == 7'h00)
		else $error("fault or value active while monitoring off");

	AST_PINS_FOLLOW_ENABLE: assert property ( // [R2]
		$rose(enable) |-> code_input_mode_out ##1 code_input_mode_out || !enable)
		else $error("code pins not switched with enable");

	AST_VALUE_COPIES_PINS: assert property ( // [R3]
		(enable && tick && ext_sel) |=> st.value == $past(code_lines_in))
		else $error("value register does not copy pins");

	AST_LEGACY_LINE6_ZERO: assert property ( // [R5]
		(enable && tick && !ext_sel) |=> st.value[6] == 1'b0)
		else $error("line 6 not zero in legacy mode");

	AST_SAMPLE_PERIOD: assert property ( // [R9]
		tick |=> !tick [*8] ##102 tick)
		else $error("sample period not 110 cycles");

	AST_STABLE_WAIT: assert property ( // [R10]
		(stable_now && chg_seen) |-> chg_age >= 10'h226)
		else $error("compare started before 55 us of stability");

	AST_NO_EVAL_WHILE_CHANGING: assert property ( // [R22]
		(enable && !stable_now) |=> $stable(st.fault))
		else $error("fault changed while code unsettled");

	AST_WINDOW_COMPARE: assert property ( // [R13]
		(enable && stable_now && !code_change) |=> st.fault == $past(mismatch))
		else $error("window compare result lost");

	AST_STATUS_SETS: assert property ( // [R15]
		st.fault |=> st.status)
		else $error("status bit not set on mismatch");

	AST_STICKY: assert property ( // [R18]
		(st.status && !read_status) |=> st.status)
		else $error("status bit dropped without a read");

	AST_READ_CLEARS: assert property ( // [R16]
		s_status_read_clean |=> !st.status ##1 (!alert_oe_out || st.status))
		else $error("status read did not clear bit and alert");

	AST_IN_WINDOW_NO_FAULT: assert property ( // [R13]
		s_in_window |=> !st.fault)
		else $error("fault raised inside window");

	AST_MASK_BLOCKS_ALERT: assert property ( // [R19]
		(st.mask[cm_pkg::MISMATCH_BIT] && st.status) |-> !alert_oe_out)
		else $error("masked status still drives alert");

	AST_ALERT_HOLDS: assert property ( // [R20]
		(alert_oe_out && !read_status &&
		!(reg_req_in.wr && reg_req_in.addr == cm_pkg::ADDR_DIG_MASK)) |=> alert_oe_out)
		else $error("alert released before status read");

endmodule

// File: test/cm_cpu_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// processor code lines and core rail converter
// ----------------------------------------
module cm_cpu_model (
	input wire logic clk_in,
	input wire logic pins_are_code_in,
	input wire logic [6:0] code_req_in,
	input wire logic [7:0] rail_req_in,
	output logic [6:0] code_lines_out,
	output logic [7:0] rail_code_out,
	output logic rail_valid_out
);
	initial begin
		code_lines_out = 7'h00;
		rail_code_out = 8'h00;
		rail_valid_out = 1'b0;
	end

	always @(posedge clk_in) begin
		// pins still on their other function carry unrelated traffic
		code_lines_out <= pins_are_code_in ? code_req_in : ~code_lines_out;
		rail_valid_out <= ~rail_valid_out;
		// between captures the converter bus shows junk, not the last value
		rail_code_out <= rail_valid_out ? ~rail_req_in : rail_req_in;
	end
endmodule

// File: test/cm_monitor_tb.sv
`timescale 1ns/1ps

module cm_monitor_tb;
	// ----------------------------------------
	// clock, stimulus and wiring
	// ----------------------------------------
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	cm_pkg::cm_reg_req_t req = '0;
	logic [6:0] code_req = 7'h00;
	logic [7:0] rail_req = 8'h80;
	logic [6:0] code_lines;
	logic [7:0] rail_code;
	logic rail_valid;
	logic [7:0] rdata;
	logic mode;
	logic alert_n;
	logic alert_oe;
	int error_cnt = 0;
	int checks = 0;

	always #50 clk_in = ~clk_in;

	cm_cpu_model cpu (.clk_in(clk_in), .pins_are_code_in(mode), .code_req_in(code_req),
		.rail_req_in(rail_req), .code_lines_out(code_lines), .rail_code_out(rail_code),
		.rail_valid_out(rail_valid));

	cm_monitor uut (.clk_in(clk_in), .rst_in(rst_in), .code_lines_in(code_lines),
		.rail_code_in(rail_code), .rail_valid_in(rail_valid), .reg_req_in(req),
		.reg_rdata_out(rdata), .code_input_mode_out(mode), .alert_n_out(alert_n),
		.alert_oe_out(alert_oe));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task check_bit(input logic got, input logic exp, input string msg);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s: got %b exp %b", $time, msg, got, exp);
		end
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task wait_cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_in);
		req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(posedge clk_in);
		req <= '0;
	endtask

	task reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk_in);
		req <= '0;
		@(posedge clk_in);
		#1 d = rdata;
	endtask

	// second read proves the first one cleared a fault that has gone away
	task clear_status;
		logic [7:0] d;
		reg_rd(8'hBE, d);
		reg_rd(8'hBE, d);
		check_byte(d, 8'h00, "status after clear");
		check_bit(alert_oe, 1'b0, "alert after clear");
	endtask

	task window_case(input logic [6:0] c, input logic [7:0] r, input logic [7:0] r_ok,
		input logic exp);
		logic [7:0] d;
		@(posedge clk_in);
		code_req <= c;
		// the old code is still compared until the next sample, so the rail moves
		// only once the new code has been taken and is not yet settled
		wait_cyc(120);
		@(posedge clk_in);
		rail_req <= r;
		wait_cyc(800);
		check_bit(alert_oe, exp, "window alert");
		reg_rd(8'hBE, d);
		check_bit(d[6], exp, "window status");
		@(posedge clk_in);
		rail_req <= r_ok;
		wait_cyc(4);
		clear_status;
	endtask

	// expected decode in 1.25 mV units, clamped at the lowest valid voltage
	function automatic int exp_dec(input int e, input logic [6:0] c);
		int leg [7] = '{20, 48, 80, 160, 320, 10, 0};
		int s = 0;
		for (int i = 0; i < 7; i++) begin
			if (c[i]) s += (e != 0) ? (5 << i) : leg[i];
		end
		return (1280 - s < 670) ? 670 : 1280 - s;
	endfunction

	task poll_value(input logic [6:0] c, output int n);
		logic [7:0] d;
		time t0;
		d = 8'hFF;
		@(posedge clk_in);
		code_req <= c;
		t0 = $time;
		for (int k = 0; k < 60 && d !== {1'b0, c}; k++) begin
			reg_rd(8'h97, d);
		end
		n = int'(($time - t0) / 100);
		check_byte(d, {1'b0, c}, "sampled code");
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task test_reset;
		logic [7:0] d;
		logic [7:0] a [7] = '{8'h00, 8'h10, 8'h35, 8'h78, 8'h97, 8'hBE, 8'h55};
		foreach (a[i]) begin
			reg_rd(a[i], d);
			check_byte(d, 8'h00, "reset value");
		end
		check_bit(mode, 1'b0, "code mode at reset");
		check_bit(alert_oe, 1'b0, "alert at reset");
		check_bit(alert_n, 1'b0, "alert pin level");
		$display("test_reset done");
	endtask

	task test_regs;
		logic [7:0] d;
		int n;
		reg_wr(8'h78, 8'h41);
		reg_rd(8'h78, d);
		check_byte(d, 8'h41, "limits");
		reg_wr(8'h97, 8'h55);
		reg_wr(8'hBE, 8'h40);
		code_req <= 7'h7F;
		wait_cyc(250);
		reg_rd(8'h97, d);
		check_byte(d, 8'h00, "value while off");
		reg_rd(8'hBE, d);
		check_byte(d, 8'h00, "status write");
		reg_wr(8'h10, 8'h80);
		wait_cyc(2);
		check_bit(mode, 1'b1, "code mode on");
		wait_cyc(250);
		reg_rd(8'h97, d);
		check_byte(d, 8'h3F, "legacy value");
		reg_wr(8'h00, 8'h40);
		wait_cyc(250);
		reg_rd(8'h97, d);
		check_byte(d, 8'h7F, "extended value");
		poll_value(7'h15, n);
		poll_value(7'h6B, n);
		check_bit(n >= 104 && n <= 118, 1'b1, "sample spacing");
		$display("test_regs done");
	endtask

	task test_window;
		reg_wr(8'h78, 8'h11);
		window_case(7'h00, 8'h82, 8'h80, 1'b0);
		window_case(7'h00, 8'h83, 8'h80, 1'b1);
		window_case(7'h00, 8'h7F, 8'h80, 1'b1);
		reg_wr(8'h78, 8'h44);
		window_case(7'h00, 8'h88, 8'h80, 1'b0);
		window_case(7'h00, 8'h89, 8'h80, 1'b1);
		window_case(7'h00, 8'h7D, 8'h80, 1'b0);
		window_case(7'h00, 8'h7C, 8'h80, 1'b1);
		$display("test_window done");
	endtask

	task test_decode;
		logic [6:0] c;
		logic [7:0] r;
		reg_wr(8'h78, 8'h12);
		for (int e = 0; e < 2; e++) begin
			// park on a code that decodes alike in both tables before switching
			window_case(7'h00, 8'h80, 8'h80, 1'b0);
			reg_wr(8'h00, (e != 0) ? 8'h40 : 8'h00);
			for (int i = 0; i < 8; i++) begin
				c = (i < 7) ? 7'(1 << i) : 7'h7F;
				r = 8'(exp_dec(e, c) / 10);
				window_case(c, r, r, 1'b0);
				window_case(c, r + 8'h03, r, 1'b1);
			end
		end
		$display("test_decode done");
	endtask

	task test_stable;
		// rail at the lowest valid voltage: out of window for both toggled codes
		@(posedge clk_in);
		rail_req <= 8'h43;
		for (int k = 0; k < 5; k++) begin
			@(posedge clk_in);
			code_req <= k[0] ? 7'h20 : 7'h40;
			wait_cyc(330);
			check_bit(alert_oe, 1'b0, "alert while code moves");
		end
		wait_cyc(110);
		check_bit(alert_oe, 1'b0, "alert before stable");
		wait_cyc(360);
		check_bit(alert_oe, 1'b1, "alert once stable");
		@(posedge clk_in);
		code_req <= 7'h00;
		rail_req <= 8'h80;
		wait_cyc(800);
		clear_status;
		$display("test_stable done");
	endtask

	task test_sticky;
		logic [7:0] d;
		@(posedge clk_in);
		rail_req <= 8'h83;
		wait_cyc(800);
		check_bit(alert_oe, 1'b1, "alert on fault");
		reg_rd(8'hBE, d);
		check_byte(d, 8'h40, "status on fault");
		wait_cyc(5);
		check_bit(alert_oe, 1'b1, "alert while fault lasts");
		@(posedge clk_in);
		rail_req <= 8'h80;
		wait_cyc(20);
		check_bit(alert_oe, 1'b1, "alert until read");
		reg_rd(8'hBE, d);
		check_byte(d, 8'h40, "sticky status");
		check_bit(alert_oe, 1'b0, "alert released");
		reg_rd(8'hBE, d);
		check_byte(d, 8'h00, "status cleared");
		$display("test_sticky done");
	endtask

	task test_mask;
		logic [7:0] d;
		reg_wr(8'h35, 8'h40);
		@(posedge clk_in);
		rail_req <= 8'h83;
		wait_cyc(800);
		check_bit(alert_oe, 1'b0, "masked alert");
		reg_rd(8'hBE, d);
		check_byte(d, 8'h40, "masked status");
		@(posedge clk_in);
		rail_req <= 8'h80;
		wait_cyc(4);
		clear_status;
		reg_wr(8'h35, 8'h00);
		reg_wr(8'h10, 8'h00);
		wait_cyc(250);
		check_bit(mode, 1'b0, "code mode off");
		reg_rd(8'h97, d);
		check_byte(d, 8'h00, "value after off");
		$display("test_mask done");
	endtask

	// ----------------------------------------
	// run and watchdog
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		test_reset;
		test_regs;
		test_window;
		test_decode;
		test_stable;
		test_sticky;
		test_mask;
		stop_test;
	end

	// the tests need about 44000 cycles
	initial begin
		#(70000 * 100);
		error_cnt++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test;
	end
endmodule
